/* pkg/smt_pkg.sv */
/*
  Package for the static memory timing readback block: register map, field
  layout, reset values and timing constants.
  Assumes a 32-bit AXI4-Lite register bus and a 20 MHz system clock.
*/
package smt_pkg;
  localparam int          NUM_CS           = 3;
  localparam logic [7:0]  ADDR_CS0_TIMING  = 8'h00;
  localparam logic [7:0]  ADDR_CS1_TIMING  = 8'h04;
  localparam logic [7:0]  ADDR_CS2_TIMING  = 8'h08;
  localparam logic [7:0]  ADDR_STAGE_TIM   = 8'h10;
  localparam logic [7:0]  ADDR_DIRECT_CMD  = 8'h14;
  localparam logic [7:0]  ADDR_MUX_MODE    = 8'h18;
  localparam logic [7:0]  ADDR_WE_WIDTH    = 8'h1c;
  localparam logic [7:0]  ADDR_DIV_COUNT   = 8'h20;
  localparam int          TR_MSB           = 19;
  localparam int          TR_LSB           = 17;
  localparam int          WP_MSB           = 13;
  localparam int          WP_LSB           = 11;
  localparam int          CEOE_MSB         = 10;
  localparam int          CEOE_LSB         = 8;
  localparam int          WC_MSB           = 7;
  localparam int          WC_LSB           = 4;
  localparam int          RC_MSB           = 3;
  localparam int          RC_LSB           = 0;
  localparam int          CMD_CS_MSB       = 1;
  localparam int          CMD_CS_LSB       = 0;
  localparam int          CMD_UPDATE_BIT   = 31;
  localparam logic [19:0] TIMING_RESET     = 20'h2b3c2;
  localparam logic [31:0] TIMING_FIELDS    = 32'h000e3fff;
  localparam logic [2:0]  MIN_3BIT         = 3'h1;
  localparam logic [3:0]  MIN_WC           = 4'h3;
  localparam logic [3:0]  MIN_RC           = 4'h2;
  localparam logic [3:0]  MUX_WP_EXTRA     = 4'h3;
  localparam logic [3:0]  MUX_CEOE_EXTRA   = 4'h1;
  localparam int          SYS_CLK_HZ       = 20000000;
  localparam int          TIMING_CLK_DIV   = 2;
  localparam int          TIMING_CLK_HZ    = SYS_CLK_HZ / TIMING_CLK_DIV;
  localparam logic [1:0]  AXI_OKAY         = 2'h0;
  localparam logic [1:0]  AXI_SLVERR       = 2'h2;
endpackage

/* logic/smt_timing_bank.sv */
/*
  Bank of per-chip-select timing registers, loaded only on an update
  command, read through a registered port.
  Assumes the caller has already checked the staged value.
*/
`timescale 1ns/1ns
module smt_timing_bank
  import smt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic [1:0]  load_sel,
  input  wire logic [19:0] load_data,
  input  wire logic [1:0]  rd_sel,
  output logic      [19:0] rd_data,
  output logic      [59:0] all_data
);
  logic [19:0] bank [NUM_CS];

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++)
    begin : g_cs
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          bank[g] <= TIMING_RESET;
        else if (load && load_sel == 2'(g))
          bank[g] <= load_data;
      end
      assign all_data[g*20 +: 20] = bank[g];
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_data <= TIMING_RESET;
    else if (rd_sel < 2'(NUM_CS))
      rd_data <= bank[rd_sel];
    else
      rd_data <= 20'h00000;
  end
endmodule

/* logic/smt_timing_readback.sv */
/*
  Static memory timing readback: AXI4-Lite slave with a staging register,
  update command, three readback registers and the half-rate timing clock
  output with the effective write-pulse figure.
  Assumes a single aclk domain and one outstanding access per direction.
*/
// Contract
// - Turnaround field bits 19:17, 1..7 cycles
// - Write-pulse field bits 13:11, 1..7 cycles
// - OE delay field bits 10:8, 1..7
// - Write-cycle field bits 7:4, 3..15
// - Read-cycle field bits 3:0, 2..15
// - Timing clock runs at half system clock
// - Staged values apply only on update command; eff_write_pulse follows the staged write pulse without one
// - Multiplexed mode stretches write pulse one cycle
`timescale 1ns/1ns
module smt_timing_readback
  import smt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             memory_timing_clock,
  output logic [3:0]       eff_write_pulse,
  output logic [59:0]      cs_timing
);
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic [19:0] staged_timing;
  logic        mux_mode;
  logic        update;
  logic [1:0]  update_sel;
  logic        reject_stage;
  logic [19:0] bank_rd;
  logic [59:0] bank_all;
  logic [1:0]  rd_sel;
  logic        rd_pend;
  logic [7:0]  rd_addr;
  logic [31:0] div_count;
  logic [2:0]  staged_write_pulse;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [1:0] cs_index(input logic [7:0] a);
    logic [1:0] r;
    r = 2'h3;
    if (a == ADDR_CS0_TIMING)
      r = 2'h0;
    else if (a == ADDR_CS1_TIMING)
      r = 2'h1;
    else if (a == ADDR_CS2_TIMING)
      r = 2'h2;
    return r;
  endfunction

  // Codes below each field's minimum are prohibited, so they are refused
  function automatic logic timing_legal(input logic [19:0] t);
    return t[TR_MSB:TR_LSB] >= MIN_3BIT
        && t[WP_MSB:WP_LSB] >= MIN_3BIT
        && t[CEOE_MSB:CEOE_LSB] >= MIN_3BIT
        && t[WC_MSB:WC_LSB] >= MIN_WC
        && t[RC_MSB:RC_LSB] >= MIN_RC;
  endfunction

  assign staged_write_pulse = staged_timing[WP_MSB:WP_LSB];

  // Write address and data are taken independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (aw_held && w_held && !s_axi_bvalid)
        aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (aw_held && w_held && !s_axi_bvalid)
        w_held <= 1'b0;
    end
  end

  // Register write and response; readback registers are read-only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      staged_timing <= TIMING_RESET;
      mux_mode      <= 1'b0;
      update        <= 1'b0;
      update_sel    <= 2'h0;
      reject_stage  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end
    else
    begin
      update <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= AXI_OKAY;
        unique case (aw_addr)
          ADDR_STAGE_TIM:
            staged_timing <= 20'(merge({12'h000, staged_timing}, w_data, w_strb) & TIMING_FIELDS);
          ADDR_DIRECT_CMD:
            if (w_strb[3] && w_data[CMD_UPDATE_BIT])
            begin
              if (timing_legal(staged_timing) && w_data[CMD_CS_MSB:CMD_CS_LSB] < 2'(NUM_CS))
              begin
                update       <= 1'b1;
                update_sel   <= w_data[CMD_CS_MSB:CMD_CS_LSB];
                reject_stage <= 1'b0;
              end
              else
              begin
                reject_stage <= 1'b1;
                s_axi_bresp  <= AXI_SLVERR;
              end
            end
          ADDR_MUX_MODE:
            if (w_strb[0])
              mux_mode <= w_data[0];
          ADDR_CS0_TIMING, ADDR_CS1_TIMING, ADDR_CS2_TIMING:
            s_axi_bresp <= AXI_SLVERR;
          default:
            s_axi_bresp <= AXI_SLVERR;
        endcase
      end
    end
  end

  smt_timing_bank u_bank
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (update),
    .load_sel  (update_sel),
    .load_data (staged_timing),
    .rd_sel    (rd_sel),
    .rd_data   (bank_rd),
    .all_data  (bank_all)
  );

  assign rd_sel = cs_index(s_axi_araddr);

  // Read: bank data registered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      rd_pend       <= 1'b0;
      rd_addr       <= 8'h00;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !rd_pend && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pend <= 1'b1;
        rd_addr <= s_axi_araddr;
      end
      else if (rd_pend)
      begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= AXI_OKAY;
        unique case (rd_addr)
          ADDR_CS0_TIMING, ADDR_CS1_TIMING, ADDR_CS2_TIMING:
            s_axi_rdata <= {12'h000, bank_rd};
          ADDR_STAGE_TIM:
            s_axi_rdata <= {12'h000, staged_timing};
          ADDR_DIRECT_CMD:
            s_axi_rdata <= {31'h00000000, reject_stage};
          ADDR_MUX_MODE:
            s_axi_rdata <= {31'h00000000, mux_mode};
          ADDR_WE_WIDTH:
            s_axi_rdata <= {28'h0000000, eff_write_pulse};
          ADDR_DIV_COUNT:
            s_axi_rdata <= div_count;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Toggling every edge gives the half-rate timing clock without a second domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      memory_timing_clock <= 1'b0;
      div_count           <= 32'h00000000;
    end
    else
    begin
      memory_timing_clock <= !memory_timing_clock;
      if (memory_timing_clock)
        div_count <= div_count + 32'h00000001;
    end
  end

  // Multiplexed bus adds one timing cycle to the strobe; the sums in
  // multiplexed mode are left to software and not checked here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eff_write_pulse <= {1'b0, TIMING_RESET[WP_MSB:WP_LSB]};
    else if (mux_mode)
      eff_write_pulse <= {1'b0, staged_write_pulse} + 4'h1;
    else
      eff_write_pulse <= {1'b0, staged_write_pulse};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cs_timing <= {NUM_CS{TIMING_RESET}};
    else
      cs_timing <= bank_all;
  end
endmodule

/* tb/smt_timing_readback_monitor.sv */
/* Checker for the timing readback block.
   Bound to the top module, sees its ports only. */
`timescale 1ns/1ns
module smt_timing_readback_monitor
  import smt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        memory_timing_clock,
  input wire logic [59:0] cs_timing
);
  logic legal;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_comb
  begin
    legal = 1'b1;
    for (int i = 0; i < NUM_CS; i++)
      legal &= cs_timing[20*i+17 +: 3] != 0 && cs_timing[20*i+11 +: 3] != 0 && cs_timing[20*i+8 +: 3] != 0
        && cs_timing[20*i+4 +: 4] >= MIN_WC && cs_timing[20*i +: 4] >= MIN_RC;
  end
  chk_tclk_half: assert property ($past(aresetn) |-> memory_timing_clock != $past(memory_timing_clock))
    else $error("timing clock missed a toggle");
  chk_fields_legal: assert property (legal)
    else $error("timing field below minimum");
  chk_bank_update: assert property ($changed(cs_timing) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
    || $past(s_axi_bvalid, 3)) else $error("bank changed without a write");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than a cycle");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a cycle");
endmodule
bind smt_timing_readback smt_timing_readback_monitor i_smt_timing_readback_monitor (.aclk, .aresetn,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .memory_timing_clock, .cs_timing);

/* tb/smt_sram_model.sv */
/* Memory-side partner: counts timing clock periods.
   Assumes the timing clock changes only on aclk. */
`timescale 1ns/1ns
module smt_sram_model
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        memory_timing_clock,
  output logic      [15:0] tclk_rises
);
  logic last_tclk;
  always_ff @(posedge aclk)
  begin
    last_tclk <= memory_timing_clock;
    if (!aresetn)
      tclk_rises <= 16'h0;
    else if (memory_timing_clock && !last_tclk)
      tclk_rises <= tclk_rises + 16'h1;
  end
endmodule

/* tb/smt_timing_readback_tb.sv */
/* Testbench: AXI4-Lite master tasks, queue of expected answers.
   Assumes the bound checker and the memory-side model. */
`timescale 1ns/1ns
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", w, e, g); end end
module smt_timing_readback_tb
  import smt_pkg::*;
;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, memory_timing_clock;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rng = 32'h7472, v, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, eff_write_pulse;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [59:0] cs_timing;
  logic [15:0] rises, r0;
  logic [19:0] bank [3];
  logic [19:0] bad [5] = '{20'h0b3c2, 20'h283c2, 20'h2b0c2, 20'h2b322, 20'h2b3c1};
  logic [33:0] exp_q [$];
  logic [33:0] exp_v, got_v;
  int          err_total = 0, n_checks = 0, cycles = 0;
  always #25 aclk = ~aclk;
  smt_timing_readback i_smt_timing_readback (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .memory_timing_clock, .eff_write_pulse, .cs_timing);
  smt_sram_model i_smt_sram_model (.aclk, .aresetn, .memory_timing_clock, .tclk_rises(rises));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    // Late ready exercises the response hold
    s_axi_bready <= 1;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask
  always @(posedge aclk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      got_v = s_axi_bready ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      exp_v = exp_q.size() ? exp_q.pop_front() : 'x;
      `CHK("response", exp_v, got_v)
    end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    bank = '{TIMING_RESET, TIMING_RESET, TIMING_RESET};
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int k = 0; k < NUM_CS; k++)
      rd(ADDR_CS0_TIMING + 8'(4 * k), {12'h0, TIMING_RESET}, AXI_OKAY);
    $display("test reset done");
    for (int k = 0; k < NUM_CS; k++)
    begin
      rng = xorshift(rng);
      v = {12'h0, rng[2:0] | 3'h1, 3'h0, rng[5:3] | 3'h1, rng[8:6] | 3'h1, rng[12:9] | 4'h3, rng[16:13] | 4'h2};
      wr(ADDR_STAGE_TIM, v, AXI_OKAY);
      rd(ADDR_STAGE_TIM, v, AXI_OKAY);
      rd(ADDR_CS0_TIMING + 8'(4 * k), {12'h0, bank[k]}, AXI_OKAY);
      wr(ADDR_DIRECT_CMD, {1'b1, 29'h0, 2'(k)}, AXI_OKAY);
      bank[k] = v[19:0];
      for (int j = 0; j < NUM_CS; j++)
        rd(ADDR_CS0_TIMING + 8'(4 * j), {12'h0, bank[j]}, AXI_OKAY);
    end
    `CHK("cs_timing", {bank[2], bank[1], bank[0]}, cs_timing)
    $display("test update done");
    foreach (bad[i])
    begin
      wr(ADDR_STAGE_TIM, {12'h0, bad[i]}, AXI_OKAY);
      wr(ADDR_DIRECT_CMD, 32'h80000000, AXI_SLVERR);
      rd(ADDR_CS0_TIMING, {12'h0, bank[0]}, AXI_OKAY);
      rd(ADDR_DIRECT_CMD, 32'h1, AXI_OKAY);
    end
    // Legal staged value, so only the select can refuse it
    wr(ADDR_STAGE_TIM, {12'h0, TIMING_RESET}, AXI_OKAY);
    wr(ADDR_DIRECT_CMD, 32'h80000003, AXI_SLVERR);
    wr(ADDR_DIRECT_CMD, 32'h80000002, AXI_OKAY);
    bank[2] = 20'h233c2;
    rd(ADDR_DIRECT_CMD, 32'h0, AXI_OKAY);
    rd(ADDR_CS2_TIMING, {12'h0, bank[2]}, AXI_OKAY);
    wr(ADDR_CS1_TIMING, 32'h0, AXI_SLVERR);
    rd(ADDR_CS1_TIMING, {12'h0, bank[1]}, AXI_OKAY);
    rd(8'h3c, 32'h0, AXI_SLVERR);
    $display("test refuse done");
    wr(ADDR_STAGE_TIM, 32'h21972, AXI_OKAY);
    wr(ADDR_MUX_MODE, 32'h1, AXI_OKAY);
    rd(ADDR_WE_WIDTH, 32'h4, AXI_OKAY);
    wr(ADDR_MUX_MODE, 32'h0, AXI_OKAY);
    rd(ADDR_WE_WIDTH, 32'h3, AXI_OKAY);
    `CHK("eff_write_pulse", 4'h3, eff_write_pulse)
    // One byte lane only: the update command needs lane 3
    s_axi_wstrb <= 4'h2;
    wr(ADDR_STAGE_TIM, 32'hffff29ff, AXI_OKAY);
    rd(ADDR_STAGE_TIM, 32'h22972, AXI_OKAY);
    wr(ADDR_DIRECT_CMD, 32'h80000002, AXI_OKAY);
    rd(ADDR_CS2_TIMING, {12'h0, bank[2]}, AXI_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_WE_WIDTH, 32'h5, AXI_OKAY);
    $display("test mux done");
    r0 = rises;
    repeat (20) @(posedge aclk);
    `CHK("tclk_rises", 16'ha, rises - r0)
    $display("test tclk done");
    test_done();
  end
endmodule
